// [core/spi_regs_pkg.sv]
package spi_regs_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_DATA      = 8'h10;
	localparam logic [7:0] OFS_POLY      = 8'h14;
	localparam logic [7:0] OFS_RX_CRC    = 8'h18;
	localparam logic [7:0] OFS_TX_CRC    = 8'h1c;

	// control register fields
	localparam int BIT_SEND_CRC_NEXT     = 4;
	localparam int BIT_CRC_ENABLE        = 5;

	// interrupt enable fields
	localparam int BIT_WAKE_IE           = 4;
	localparam int BIT_FAULT_IE          = 5;
	localparam int BIT_RX_FULL_IE        = 6;
	localparam int BIT_TX_EMPTY_IE       = 7;

	// status fields
	localparam int BIT_RX_FULL           = 0;
	localparam int BIT_TX_EMPTY          = 1;
	localparam int BIT_WAKE              = 3;
	localparam int BIT_CRC_ERR           = 4;
	localparam int BIT_MODE_FAULT        = 5;
	localparam int BIT_OVERRUN           = 6;
	localparam int BIT_BUSY              = 7;

	// reset values
	localparam logic [31:0] RST_IRQ_EN   = 32'h0000_0000;
	localparam logic [31:0] RST_STATUS   = 32'h0000_022c;
	localparam logic [31:0] RST_DATA     = 32'h0000_0000;
	localparam logic [31:0] RST_POLY     = 32'h0000_0007;
	localparam logic [31:0] RST_CRC      = 32'h0000_0000;
	localparam logic [31:0] RST_CONTROL  = 32'h0000_0000;

endpackage : spi_regs_pkg

// [core/spi_status_irq_crc_regs.sv]
`timescale 1ns/1ps

module spi_status_irq_crc_regs #(
	parameter int DATA_W = 8
) (
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	// register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	// shift engine side, same clock
	input  wire logic              i_if_enabled,
	input  wire logic              i_full_duplex,
	input  wire logic              i_busy,
	input  wire logic              i_rx_valid,
	input  wire logic              i_rx_is_crc,
	input  wire logic [DATA_W-1:0] i_rx_byte,
	input  wire logic              i_tx_taken,
	output logic                   o_tx_pending,
	output logic      [DATA_W-1:0] o_tx_byte,
	output logic                   o_tx_is_crc,
	input  wire logic              i_wake,
	input  wire logic              i_mode_fault,
	output logic                   o_irq
);

	// one step of a msb-first crc over a whole byte
	function automatic logic [DATA_W-1:0] crc_byte(
		input logic [DATA_W-1:0] crc,
		input logic [DATA_W-1:0] data,
		input logic [DATA_W-1:0] poly
	);
		logic [DATA_W-1:0] c;
		c = crc;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (c[DATA_W-1] ^ data[i]) begin
				c = {c[DATA_W-2:0], 1'b0} ^ poly;
			end else begin
				c = {c[DATA_W-2:0], 1'b0};
			end
		end
		return c;
	endfunction : crc_byte

	logic [DATA_W-1:0] tx_data_r;
	logic              tx_full_r;
	logic [DATA_W-1:0] rx_data_r;
	logic              rx_full_r;
	logic [DATA_W-1:0] poly_r;
	logic [DATA_W-1:0] rx_crc_r;
	logic [DATA_W-1:0] tx_crc_r;
	logic              crc_en_r;
	logic              send_next_r;
	logic              wake_ie_r;
	logic              fault_ie_r;
	logic              rx_ie_r;
	logic              tx_ie_r;
	logic              wake_flag_r;
	logic              crc_err_r;
	logic              mode_fault_r;
	logic              overrun_r;
	logic [31:0]       rdata_r;

	// address decode
	wire wr_ctrl   = i_wr && (i_addr == spi_regs_pkg::OFS_CONTROL);
	wire wr_ie     = i_wr && (i_addr == spi_regs_pkg::OFS_IRQ_EN);
	wire wr_status = i_wr && (i_addr == spi_regs_pkg::OFS_STATUS);
	wire wr_data   = i_wr && (i_addr == spi_regs_pkg::OFS_DATA);
	wire wr_poly   = i_wr && (i_addr == spi_regs_pkg::OFS_POLY);
	wire rd_data   = i_rd && (i_addr == spi_regs_pkg::OFS_DATA);

	// clear-by-zero requests; a one written leaves the flag alone
	wire clr_wake  = wr_status && !i_wdata[spi_regs_pkg::BIT_WAKE];
	wire clr_crc   = wr_status && !i_wdata[spi_regs_pkg::BIT_CRC_ERR];
	wire clr_mode  = wr_status && !i_wdata[spi_regs_pkg::BIT_MODE_FAULT];
	wire clr_ovr   = wr_status && !i_wdata[spi_regs_pkg::BIT_OVERRUN];

	// checksum enable may only move while the interface is off
	wire crc_en_wr  = wr_ctrl && !i_if_enabled;
	wire crc_en_nxt = crc_en_wr ? i_wdata[spi_regs_pkg::BIT_CRC_ENABLE]
		: crc_en_r;
	wire crc_clear  = crc_en_wr && i_wdata[spi_regs_pkg::BIT_CRC_ENABLE];
	wire crc_active = crc_en_r && i_full_duplex;

	// receive and transmit side events
	wire rx_data_in   = i_rx_valid && !i_rx_is_crc;
	wire rx_crc_in    = i_rx_valid && i_rx_is_crc;
	wire rx_mismatch  = rx_crc_in && crc_active && (i_rx_byte != rx_crc_r);
	wire rx_overrun   = i_rx_valid && rx_full_r && !rd_data;
	wire tx_data_out  = i_tx_taken && !send_next_r;

	// status word as software sees it
	wire [7:0] status_word = {
		i_busy,
		overrun_r,
		mode_fault_r,
		crc_err_r,
		wake_flag_r,
		1'b0,
		!tx_full_r,
		rx_full_r
	};

	wire err_any = crc_err_r || mode_fault_r || overrun_r;

	// read mux; unmapped offsets answer zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_addr)
			spi_regs_pkg::OFS_CONTROL: begin
				rd_mux[spi_regs_pkg::BIT_SEND_CRC_NEXT] = send_next_r;
				rd_mux[spi_regs_pkg::BIT_CRC_ENABLE]    = crc_en_r;
			end
			spi_regs_pkg::OFS_IRQ_EN: begin
				rd_mux[spi_regs_pkg::BIT_WAKE_IE]     = wake_ie_r;
				rd_mux[spi_regs_pkg::BIT_FAULT_IE]    = fault_ie_r;
				rd_mux[spi_regs_pkg::BIT_RX_FULL_IE]  = rx_ie_r;
				rd_mux[spi_regs_pkg::BIT_TX_EMPTY_IE] = tx_ie_r;
			end
			spi_regs_pkg::OFS_STATUS: rd_mux[7:0] = status_word;
			spi_regs_pkg::OFS_DATA:   rd_mux[DATA_W-1:0] = rx_data_r;
			spi_regs_pkg::OFS_POLY:   rd_mux[DATA_W-1:0] = poly_r;
			spi_regs_pkg::OFS_RX_CRC: rd_mux[DATA_W-1:0] = rx_crc_r;
			spi_regs_pkg::OFS_TX_CRC: rd_mux[DATA_W-1:0] = tx_crc_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// control and interrupt enable registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			crc_en_r    <= spi_regs_pkg::RST_CONTROL[spi_regs_pkg::BIT_CRC_ENABLE];
			send_next_r <=
				spi_regs_pkg::RST_CONTROL[spi_regs_pkg::BIT_SEND_CRC_NEXT];
			wake_ie_r   <= spi_regs_pkg::RST_IRQ_EN[spi_regs_pkg::BIT_WAKE_IE];
			fault_ie_r  <= spi_regs_pkg::RST_IRQ_EN[spi_regs_pkg::BIT_FAULT_IE];
			rx_ie_r     <= spi_regs_pkg::RST_IRQ_EN[spi_regs_pkg::BIT_RX_FULL_IE];
			tx_ie_r     <= spi_regs_pkg::RST_IRQ_EN[spi_regs_pkg::BIT_TX_EMPTY_IE];
		end else begin
			crc_en_r <= crc_en_nxt;
			// the checksum byte going out ends the request; a new write wins
			if (wr_ctrl) begin
				send_next_r <= i_wdata[spi_regs_pkg::BIT_SEND_CRC_NEXT];
			end else if (i_tx_taken && send_next_r) begin
				send_next_r <= 1'b0;
			end
			if (wr_ie) begin
				wake_ie_r  <= i_wdata[spi_regs_pkg::BIT_WAKE_IE];
				fault_ie_r <= i_wdata[spi_regs_pkg::BIT_FAULT_IE];
				rx_ie_r    <= i_wdata[spi_regs_pkg::BIT_RX_FULL_IE];
				tx_ie_r    <= i_wdata[spi_regs_pkg::BIT_TX_EMPTY_IE];
			end
		end
	end

	// transmit buffer; a write in the cycle the engine takes a byte wins
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_data_r <= spi_regs_pkg::RST_DATA[DATA_W-1:0];
			tx_full_r <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_data_r <= i_wdata[DATA_W-1:0];
				tx_full_r <= 1'b1;
			end else if (tx_data_out) begin
				tx_full_r <= 1'b0;
			end
		end
	end

	// receive buffer; a new byte in the cycle of a read keeps the flag set
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_data_r <= spi_regs_pkg::RST_DATA[DATA_W-1:0];
			rx_full_r <= 1'b0;
		end else begin
			if (i_rx_valid) begin
				rx_data_r <= i_rx_byte;
				rx_full_r <= 1'b1;
			end else if (rd_data) begin
				rx_full_r <= 1'b0;
			end
		end
	end

	// polynomial register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			poly_r <= spi_regs_pkg::RST_POLY[DATA_W-1:0];
		end else if (wr_poly) begin
			poly_r <= i_wdata[DATA_W-1:0];
		end
	end

	// running checksums; the received checksum byte is compared, not folded
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rx_crc_r <= spi_regs_pkg::RST_CRC[DATA_W-1:0];
			tx_crc_r <= spi_regs_pkg::RST_CRC[DATA_W-1:0];
		end else if (crc_clear) begin
			rx_crc_r <= '0;
			tx_crc_r <= '0;
		end else begin
			if (rx_data_in && crc_active) begin
				rx_crc_r <= crc_byte(rx_crc_r, i_rx_byte, poly_r);
			end
			if (tx_data_out && crc_active) begin
				tx_crc_r <= crc_byte(tx_crc_r, tx_data_r, poly_r);
			end
		end
	end

	// sticky flags: a hardware set beats a software clear in the same cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wake_flag_r  <= spi_regs_pkg::RST_STATUS[spi_regs_pkg::BIT_WAKE];
			crc_err_r    <= spi_regs_pkg::RST_STATUS[spi_regs_pkg::BIT_CRC_ERR];
			mode_fault_r <= spi_regs_pkg::RST_STATUS[spi_regs_pkg::BIT_MODE_FAULT];
			overrun_r    <= spi_regs_pkg::RST_STATUS[spi_regs_pkg::BIT_OVERRUN];
		end else begin
			if (i_wake) begin
				wake_flag_r <= 1'b1;
			end else if (clr_wake) begin
				wake_flag_r <= 1'b0;
			end
			if (rx_mismatch) begin
				crc_err_r <= 1'b1;
			end else if (clr_crc) begin
				crc_err_r <= 1'b0;
			end
			if (i_mode_fault) begin
				mode_fault_r <= 1'b1;
			end else if (clr_mode) begin
				mode_fault_r <= 1'b0;
			end
			if (rx_overrun) begin
				overrun_r <= 1'b1;
			end else if (clr_ovr) begin
				overrun_r <= 1'b0;
			end
		end
	end

	// engine-facing outputs; crc byte replaces the buffer when requested
	assign o_tx_is_crc  = send_next_r;
	assign o_tx_byte    = send_next_r ? tx_crc_r : tx_data_r;
	assign o_tx_pending = tx_full_r || send_next_r;
	assign o_rdata      = rdata_r;

	// interrupt is a level, so clearing the source drops it
	wire irq_wake  = wake_ie_r && wake_flag_r;
	wire irq_fault = fault_ie_r && err_any;
	wire irq_rx    = rx_ie_r && rx_full_r;
	wire irq_tx    = tx_ie_r && !tx_full_r;
	assign o_irq   = irq_wake || irq_fault || irq_rx || irq_tx;

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	property p_wake_irq;
		wake_ie_r && wake_flag_r |-> o_irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq)
		else $error("wake source enabled but no interrupt");

	property p_fault_irq;
		fault_ie_r && err_any |-> o_irq;
	endproperty
	a_fault_irq: assert property (p_fault_irq)
		else $error("error flag enabled but no interrupt");
	property p_rx_irq;
		i_rx_valid && rx_ie_r ##1 rx_ie_r |-> o_irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq)
		else $error("receive byte enabled but no interrupt");
	property p_tx_irq;
		tx_data_out && !wr_data ##1 tx_ie_r |-> o_irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("empty transmit buffer enabled but no interrupt");
	property p_irq_cause;
		o_irq |-> (wake_ie_r && wake_flag_r) || (fault_ie_r && err_any)
			|| (rx_ie_r && rx_full_r) || (tx_ie_r && !tx_full_r);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without enabled source");
	// status as software would read it, right after the event
	property p_rx_flag;
		i_rx_valid |=> status_word[spi_regs_pkg::BIT_RX_FULL];
	endproperty
	a_rx_flag: assert property (p_rx_flag)
		else $error("receive flag not shown after byte");
	property p_tx_flag;
		wr_data |=> !status_word[spi_regs_pkg::BIT_TX_EMPTY];
	endproperty
	a_tx_flag: assert property (p_tx_flag)
		else $error("transmit empty after data write");
	property p_wake_set;
		i_wake |=> wake_flag_r [*2] or (wake_flag_r ##1 $fell(wake_flag_r)
			&& $past(clr_wake));
	endproperty
	a_wake_set: assert property (p_wake_set)
		else $error("wake flag not set by event");
	property p_crc_err;
		rx_mismatch |=> crc_err_r;
	endproperty
	a_crc_err: assert property (p_crc_err)
		else $error("checksum mismatch not flagged");
	property p_flag_hold;
		crc_err_r && !clr_crc |=> crc_err_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("checksum error flag lost without clear");
	property p_overrun;
		i_rx_valid && rx_full_r && !rd_data |=> overrun_r;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");
	property p_busy_read;
		i_rd && (i_addr == spi_regs_pkg::OFS_STATUS)
			|=> o_rdata[spi_regs_pkg::BIT_BUSY] == $past(i_busy);
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy bit does not follow engine");
	property p_data_read;
		rd_data |=> o_rdata[DATA_W-1:0] == $past(rx_data_r);
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("data port read returns wrong byte");
	property p_poly_wr;
		wr_poly |=> poly_r == $past(i_wdata[DATA_W-1:0]);
	endproperty
	a_poly_wr: assert property (p_poly_wr)
		else $error("polynomial write lost");
	property p_crc_clear;
		crc_clear |=> rx_crc_r == '0 && tx_crc_r == '0 && crc_en_r;
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("checksums not cleared on enable");
	// a control write while the engine runs must not move the enable
	property p_crc_lock;
		wr_ctrl && i_if_enabled |=> $stable(crc_en_r);
	endproperty
	a_crc_lock: assert property (p_crc_lock)
		else $error("checksum enable changed while running");
	property p_send_crc;
		send_next_r |-> o_tx_byte == tx_crc_r;
	endproperty
	a_send_crc: assert property (p_send_crc)
		else $error("checksum byte not selected");
	property p_one_ignored;
		wr_status && i_wdata[spi_regs_pkg::BIT_WAKE] && wake_flag_r
			|=> wake_flag_r;
	endproperty
	a_one_ignored: assert property (p_one_ignored)
		else $error("writing one cleared wake flag");

	c_mismatch: cover property (rx_mismatch ##1 crc_err_r);
	c_overrun:  cover property (rx_overrun ##1 o_irq);
	c_crc_send: cover property (send_next_r && i_tx_taken);
	c_crc_lock: cover property (wr_ctrl && i_if_enabled && crc_en_r);

endmodule : spi_status_irq_crc_regs

// [testbench/spi_engine_model.sv]
`timescale 1ns/1ps

// shift engine stand-in: one frame per start pulse, link clock of eight
// system clocks per period that stands still between frames
module spi_engine_model (
	input  wire logic       i_clk,
	input  wire logic       i_start,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_is_crc,
	input  wire logic [3:0] i_gap,
	input  wire logic       i_tx_pending,
	input  wire logic [7:0] i_tx_byte,
	output logic            o_sck,
	output logic            o_busy,
	output logic            o_rx_valid,
	output logic            o_rx_is_crc,
	output logic [7:0]      o_rx_byte,
	output logic            o_tx_taken,
	output logic [7:0]      o_got
);
	// eight link clock periods, then a stall of i_gap cycles (slow peer)
	task automatic frame;
		o_busy <= 1'b1;
		repeat (8) begin
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		repeat (i_gap) @(posedge i_clk);
		o_rx_valid  <= 1'b1;
		o_rx_is_crc <= i_is_crc;
		o_rx_byte   <= i_byte;
		o_tx_taken  <= i_tx_pending;
		if (i_tx_pending)
			o_got <= i_tx_byte;
		@(posedge i_clk);
		// released byte lines change, so a stale value cannot pass
		o_rx_valid  <= 1'b0;
		o_rx_is_crc <= 1'b0;
		o_rx_byte   <= ~i_byte;
		o_tx_taken  <= 1'b0;
		o_busy      <= 1'b0;
	endtask : frame

	// idle until a start pulse is seen on a rising edge
	initial begin
		o_sck = 1'b0;
		o_busy = 1'b0;
		o_rx_valid = 1'b0;
		o_rx_is_crc = 1'b0;
		o_rx_byte = 8'h00;
		o_tx_taken = 1'b0;
		o_got = 8'h00;
		forever begin
			@(posedge i_clk);
			if (i_start)
				frame();
		end
	end
endmodule : spi_engine_model

// [testbench/test_spi_status_irq_crc_regs.sv]
`timescale 1ns/1ps

module test_spi_status_irq_crc_regs;
	logic        i_clk, i_nrst, i_wr, i_rd, i_if_enabled, i_full_duplex;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, rv;
	logic        i_wake, i_mode_fault, o_tx_pending, o_tx_is_crc, o_irq;
	logic [7:0]  o_tx_byte, got, b_byte, poly, erx, etx, t, r;
	logic        b_start, b_crc, busy, rx_valid, rx_is_crc, tx_taken, sck;
	logic [7:0]  rx_byte;
	logic [3:0]  b_gap;
	int          error_cnt, checks, n, seed;

	spi_status_irq_crc_regs u_spi_status_irq_crc_regs (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_if_enabled(i_if_enabled), .i_full_duplex(i_full_duplex),
		.i_busy(busy), .i_rx_valid(rx_valid), .i_rx_is_crc(rx_is_crc),
		.i_rx_byte(rx_byte), .i_tx_taken(tx_taken),
		.o_tx_pending(o_tx_pending), .o_tx_byte(o_tx_byte),
		.o_tx_is_crc(o_tx_is_crc), .i_wake(i_wake),
		.i_mode_fault(i_mode_fault), .o_irq(o_irq));

	spi_engine_model u_spi_engine_model (
		.i_clk(i_clk), .i_start(b_start), .i_byte(b_byte),
		.i_is_crc(b_crc), .i_gap(b_gap), .i_tx_pending(o_tx_pending),
		.i_tx_byte(o_tx_byte), .o_sck(sck), .o_busy(busy),
		.o_rx_valid(rx_valid), .o_rx_is_crc(rx_is_crc),
		.o_rx_byte(rx_byte), .o_tx_taken(tx_taken), .o_got(got));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic results;
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk

	// one-cycle bus strobes launched right after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	// msb-first checksum, zero start, no final inversion
	function automatic logic [7:0] crc8(input logic [7:0] c, d, p);
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? p : 8'h00);
		return c;
	endfunction : crc8

	task automatic start(input logic [7:0] b, input logic c);
		@(posedge i_clk);
		b_byte <= b;
		b_crc <= c;
		b_gap <= 4'($random(seed));
		b_start <= 1'b1;
		@(posedge i_clk);
		b_start <= 1'b0;
	endtask : start

	// bounded wait for the peer to end its frame
	task automatic fin;
		for (n = 0; n < 300; n++) begin
			@(posedge i_clk);
			#1;
			if (!busy)
				break;
		end
		@(posedge i_clk);
		if (n == 300) begin
			error_cnt++;
			results();
		end
	endtask : fin

	initial begin
		{i_wr, i_rd, i_wake, i_mode_fault, b_start, b_crc} = '0;
		{i_addr, i_wdata, b_byte, b_gap, erx, etx} = '0;
		{i_if_enabled, i_full_duplex, i_nrst} = 3'b010;
		error_cnt = 0;
		checks = 0;
		seed = 32'h1c2f16e2;
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		// reset values, unmapped place reads zero
		rd(spi_regs_pkg::OFS_IRQ_EN, rv); chk(rv, 32'h0);
		rd(spi_regs_pkg::OFS_POLY, rv); chk(rv, 32'h7);
		rd(spi_regs_pkg::OFS_RX_CRC, rv); chk(rv, 32'h0);
		rd(spi_regs_pkg::OFS_TX_CRC, rv); chk(rv, 32'h0);
		rd(8'h20, rv); chk(rv, 32'h0);
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'hfb, 32'h2a);
		// interrupt sources one by one
		wr(spi_regs_pkg::OFS_IRQ_EN, 32'h10); chk(o_irq, 1);
		wr(spi_regs_pkg::OFS_STATUS, 32'hf7); chk(o_irq, 0);
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'hfb, 32'h22);
		wr(spi_regs_pkg::OFS_IRQ_EN, 32'h20); chk(o_irq, 1);
		wr(spi_regs_pkg::OFS_STATUS, 32'h0); chk(o_irq, 0);
		@(posedge i_clk) i_wake <= 1'b1;
		@(posedge i_clk) i_wake <= 1'b0;
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'hfb, 32'h0a);
		wr(spi_regs_pkg::OFS_IRQ_EN, 32'h80); chk(o_irq, 1);
		wr(spi_regs_pkg::OFS_IRQ_EN, 32'h0); chk(o_irq, 0);
		// checksum setup while the interface is disabled
		i_full_duplex <= 1'b1;
		poly = 8'($random(seed)) | 8'h01;
		wr(spi_regs_pkg::OFS_POLY, {24'h0, poly});
		rd(spi_regs_pkg::OFS_POLY, rv); chk(rv, {24'h0, poly});
		wr(spi_regs_pkg::OFS_CONTROL, 32'h20);
		for (int k = 0; k < 4; k++) begin
			t = 8'($random(seed));
			r = (k == 0) ? 8'hff : 8'($random(seed));
			wr(spi_regs_pkg::OFS_DATA, {24'h0, t});
			chk(o_tx_pending, 1);
			rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv[1], 0);
			start(r, 1'b0);
			rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv[7], 1);
			fin();
			chk(got, t);
			rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'h83, 32'h03);
			wr(spi_regs_pkg::OFS_IRQ_EN, 32'h40); chk(o_irq, 1);
			rd(spi_regs_pkg::OFS_DATA, rv); chk(rv, {24'h0, r});
			chk(o_irq, 0);
			wr(spi_regs_pkg::OFS_IRQ_EN, 32'h0);
			erx = crc8(erx, r, poly);
			etx = crc8(etx, t, poly);
		end
		// results read only while idle
		chk(busy, 0);
		rd(spi_regs_pkg::OFS_RX_CRC, rv); chk(rv, {24'h0, erx});
		rd(spi_regs_pkg::OFS_TX_CRC, rv); chk(rv, {24'h0, etx});
		// engine on: the enable bit is locked, the next-byte request is not
		i_if_enabled <= 1'b1;
		wr(spi_regs_pkg::OFS_CONTROL, 32'h10); chk(o_tx_is_crc, 1);
		rd(spi_regs_pkg::OFS_CONTROL, rv); chk(rv, 32'h30);
		start(erx, 1'b1);
		fin();
		chk(got, etx);
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv[4], 0);
		start(~erx, 1'b1);
		fin();
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv[4], 1);
		rd(spi_regs_pkg::OFS_DATA, rv);
		wr(spi_regs_pkg::OFS_STATUS, 32'h8f);
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'h70, 32'h0);
		// half duplex leaves the checksum alone; two unread bytes overrun
		i_full_duplex <= 1'b0;
		start(8'h5a, 1'b0);
		fin();
		i_full_duplex <= 1'b1;
		rd(spi_regs_pkg::OFS_RX_CRC, rv); chk(rv, {24'h0, erx});
		start(8'ha5, 1'b0);
		fin();
		@(posedge i_clk) i_mode_fault <= 1'b1;
		@(posedge i_clk) i_mode_fault <= 1'b0;
		rd(spi_regs_pkg::OFS_STATUS, rv); chk(rv & 32'h60, 32'h60);
		i_if_enabled <= 1'b0;
		wr(spi_regs_pkg::OFS_CONTROL, 32'h20);
		rd(spi_regs_pkg::OFS_RX_CRC, rv); chk(rv, 32'h0);
		rd(spi_regs_pkg::OFS_TX_CRC, rv); chk(rv, 32'h0);
		results();
	end
endmodule : test_spi_status_irq_crc_regs
